/* File: verilog/cis_sequencer.sv */
// Interrupt acceptance and acknowledge sequencer of an 8-bit processor
`timescale 1ns/1ps
module cis_sequencer
  import cis_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         irq_n_i,
  input  wire logic         nmi_n_i,
  input  wire logic         bus_request_n_i,
  input  wire logic         last_tstate_i,
  input  wire cis_instr_t   instr_i,
  input  wire logic [7:0]   data_i,
  output logic              opcode_cycle_n_o,
  output logic              io_request_n_o,
  output logic              read_n_o,
  output logic              nmi_fetch_o,
  output logic              bus_grant_o,
  output cis_service_t      service_o,
  output logic              irq_enabled_o,
  output logic [1:0]        irq_mode_o
);

  logic [1:0]  irq_sync_reg;
  logic [1:0]  nmi_sync_reg;
  logic [1:0]  breq_sync_reg;
  logic        nmi_prev_reg;
  logic        nmi_pend_reg;
  logic        iff1_reg;
  logic        iff2_reg;
  logic [1:0]  mode_reg;
  logic [7:0]  page_reg;
  cis_state_t  state_reg;
  logic [1:0]  cnt_reg;
  logic        nmi_edge;
  logic        take_nmi;
  logic        take_irq;
  logic        boundary;

  // Asynchronous pins pass two flops before use
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_sync_reg   <= 2'h0;
      nmi_sync_reg   <= 2'h0;
      breq_sync_reg  <= 2'h0;
    end
    else
    begin
      irq_sync_reg   <= {irq_sync_reg[0], ~irq_n_i};
      nmi_sync_reg   <= {nmi_sync_reg[0], ~nmi_n_i};
      breq_sync_reg  <= {breq_sync_reg[0], ~bus_request_n_i};
    end
  end

  assign boundary = last_tstate_i && (state_reg == CIS_IDLE);
  // Edge latch holds a short NMI pulse until a boundary with no bus request takes it
  assign nmi_edge = nmi_sync_reg[1] && !nmi_prev_reg;
  assign take_nmi = boundary && !breq_sync_reg[1] && nmi_pend_reg;
  assign take_irq = boundary && !breq_sync_reg[1] && !nmi_pend_reg
                    && irq_sync_reg[1] && iff1_reg;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      nmi_prev_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
    end
    else
    begin
      nmi_prev_reg <= nmi_sync_reg[1];
      // A new edge in the accept cycle wins over the clear
      if (nmi_edge)
        nmi_pend_reg <= 1'b1;
      else if (take_nmi)
        nmi_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_grant_o <= 1'b0;
    else
      bus_grant_o <= boundary && breq_sync_reg[1];
  end

  // Enable flags; NMI keeps the old state in the second flag
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      iff1_reg <= 1'b0;
      iff2_reg <= 1'b0;
    end
    else if (take_nmi)
    begin
      iff1_reg <= 1'b0;
      iff2_reg <= iff1_reg;
    end
    else if (take_irq)
    begin
      iff1_reg <= 1'b0;
      iff2_reg <= 1'b0;
    end
    else if (instr_i.enable)
    begin
      iff1_reg <= 1'b1;
      iff2_reg <= 1'b1;
    end
    else if (instr_i.disable_)
    begin
      iff1_reg <= 1'b0;
      iff2_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_reg <= CIS_MODE_RESET;
      page_reg <= CIS_IREG_RESET;
    end
    else
    begin
      // Code 3 is not a mode; it is ignored
      if (instr_i.mode_sel && instr_i.mode != 2'h3)
        mode_reg <= instr_i.mode;
      if (instr_i.load_page)
        page_reg <= instr_i.page;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= CIS_IDLE;
      cnt_reg   <= 2'h0;
    end
    else
    begin
      case (state_reg)
        CIS_IDLE:
        begin
          cnt_reg <= 2'h0;
          if (take_nmi)
            state_reg <= CIS_NMIF;
          else if (take_irq)
            state_reg <= CIS_ACK;
        end
        CIS_NMIF:
          state_reg <= CIS_IDLE;
        CIS_ACK:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == CIS_ACK_TSTATES - 2'h1)
          begin
            state_reg <= CIS_WAIT;
            cnt_reg   <= 2'h0;
          end
        end
        CIS_WAIT:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == CIS_ACK_WAITS - 2'h1)
            state_reg <= CIS_LATCH;
        end
        CIS_LATCH:
          state_reg <= CIS_IDLE;
        default:
          state_reg <= CIS_IDLE;
      endcase
    end
  end

  // Bus strobes; read stays high throughout acknowledge
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      opcode_cycle_n_o <= 1'b1;
      io_request_n_o   <= 1'b1;
      read_n_o         <= 1'b1;
      nmi_fetch_o      <= 1'b0;
    end
    else
    begin
      opcode_cycle_n_o <= !(take_irq || take_nmi ||
                            (state_reg == CIS_ACK) || (state_reg == CIS_WAIT));
      io_request_n_o   <= !(take_irq || (state_reg == CIS_ACK && cnt_reg == 2'h0)
                            || state_reg == CIS_WAIT);
      read_n_o         <= !take_nmi;
      nmi_fetch_o      <= take_nmi;
    end
  end

  // Service order to the execution unit; NMI opcode is discarded
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      service_o <= '0;
    else
    begin
      service_o.valid <= 1'b0;
      if (state_reg == CIS_NMIF)
      begin
        service_o.valid  <= 1'b1;
        service_o.nmi    <= 1'b1;
        service_o.mode   <= mode_reg;
        service_o.target <= CIS_NMI_ADDR;
        service_o.opcode <= 8'h00;
      end
      else if (state_reg == CIS_LATCH)
      begin
        service_o.valid  <= 1'b1;
        service_o.nmi    <= 1'b0;
        service_o.mode   <= mode_reg;
        service_o.opcode <= data_i;
        if (mode_reg == CIS_MODE_1)
          service_o.target <= CIS_MODE1_ADDR;
        else if (mode_reg == CIS_MODE_2)
          service_o.target <= {page_reg, data_i};
        else
          service_o.target <= 16'h0000;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_enabled_o <= 1'b0;
      irq_mode_o    <= CIS_MODE_RESET;
    end
    else
    begin
      irq_enabled_o <= iff1_reg;
      irq_mode_o    <= mode_reg;
    end
  end

endmodule

/* File: verilog/cis_pkg.sv */
// Package: constants and types for the interrupt sequencer
package cis_pkg;
  localparam logic [15:0] CIS_NMI_ADDR    = 16'h0066;
  localparam logic [15:0] CIS_MODE1_ADDR  = 16'h0038;
  localparam logic [1:0]  CIS_MODE_RESET  = 2'h0;
  localparam logic [1:0]  CIS_MODE_1      = 2'h1;
  localparam logic [1:0]  CIS_MODE_2      = 2'h2;
  localparam logic [1:0]  CIS_ACK_WAITS   = 2'h2;
  localparam logic [1:0]  CIS_ACK_TSTATES = 2'h2;
  localparam logic [7:0]  CIS_IREG_RESET  = 8'h00;

  typedef enum logic [2:0] {
    CIS_IDLE  = 3'b000,
    CIS_NMIF  = 3'b001,
    CIS_ACK   = 3'b010,
    CIS_WAIT  = 3'b011,
    CIS_LATCH = 3'b100
  } cis_state_t;

  // Instruction decode strobes from the execution unit
  typedef struct packed {
    logic       enable;
    logic       disable_;
    logic       mode_sel;
    logic [1:0] mode;
    logic       load_page;
    logic [7:0] page;
  } cis_instr_t;

  // Service request handed from the sequencer to the execution unit
  typedef struct packed {
    logic        valid;
    logic        nmi;
    logic [1:0]  mode;
    logic [15:0] target;
    logic [7:0]  opcode;
  } cis_service_t;
endpackage

/* File: verif/cis_seq_sva.sv */
// Checker: port assertions of the interrupt sequencer
`timescale 1ns/1ps
module cis_seq_sva
  import cis_pkg::*;
(
  input wire logic         clock_i,
  input wire logic         rst_n_i,
  input wire cis_instr_t   instr_i,
  input wire logic [7:0]   data_i,
  input wire logic         opcode_cycle_n_o,
  input wire logic         io_request_n_o,
  input wire logic         read_n_o,
  input wire logic         nmi_fetch_o,
  input wire logic         bus_grant_o,
  input wire cis_service_t service_o,
  input wire logic         irq_enabled_o,
  input wire logic [1:0]   irq_mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_no_read: assert property
    (!io_request_n_o && !opcode_cycle_n_o |-> read_n_o) else $error("read in ack");
  a_ack_two_waits: assert property
    ($fell(opcode_cycle_n_o) && !io_request_n_o |=> !io_request_n_o ##1 io_request_n_o
     ##1 !io_request_n_o [*2]) else $error("ack strobe shape");
  a_ack_service: assert property
    ($fell(opcode_cycle_n_o) && !io_request_n_o |-> ##5 service_o.valid && !service_o.nmi)
    else $error("ack without service");
  a_nmi_restart: assert property
    (nmi_fetch_o |-> !read_n_o ##1 service_o.valid && service_o.target == CIS_NMI_ADDR)
    else $error("nmi restart");
  a_mode1_target: assert property
    (service_o.valid && !service_o.nmi && service_o.mode == CIS_MODE_1
     |-> service_o.target == CIS_MODE1_ADDR) else $error("mode 1 target");
  a_mode2_target: assert property
    (service_o.valid && !service_o.nmi && service_o.mode == CIS_MODE_2
     |-> service_o.target[7:0] == $past(data_i)) else $error("mode 2 vector");
  // Software may re-enable during the sequence, so check right after acceptance
  a_accept_mask: assert property
    ($fell(opcode_cycle_n_o) |=> !irq_enabled_o) else $error("enable kept");
  a_mode_set: assert property
    (instr_i.mode_sel && instr_i.mode != 2'h3 |-> ##2 irq_mode_o == $past(instr_i.mode, 2))
    else $error("mode not set");
  a_grant_alone: assert property
    (bus_grant_o |-> io_request_n_o && read_n_o && !nmi_fetch_o) else $error("grant mixed");
  a_di_mask: assert property
    (instr_i.disable_ && !instr_i.enable |-> ##2 !irq_enabled_o) else $error("disable ignored");
endmodule

/* File: verif/cis_periph.sv */
// Peripheral model: raises the shared request and answers acknowledge
`timescale 1ns/1ps
module cis_periph
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       raise_i,
  input  wire logic [7:0] vector_i,
  input  wire logic       io_request_n_i,
  input  wire logic       opcode_cycle_n_i,
  output logic            irq_n_o,
  output logic [7:0]      data_o
);
  logic ack;
  logic pend_reg;
  // No dedicated pin: the cycle is recognised from its strobes
  assign ack = !io_request_n_i && !opcode_cycle_n_i;
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      pend_reg <= 1'h0;
    else if (ack)
      pend_reg <= 1'h0;
    else if (raise_i)
      pend_reg <= 1'h1;
  assign irq_n_o = !pend_reg;
  // Outside acknowledge the bus shows the inverse, never a stale vector
  assign data_o = ack ? vector_i : ~vector_i;
endmodule

/* File: verif/cis_sequencer_tb.sv */
// Testbench: interrupt sequencer scenarios
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module cis_sequencer_tb
  import cis_pkg::*;
;
  localparam cis_instr_t IRQ_ON  = 14'h2000;
  localparam cis_instr_t IRQ_OFF = 14'h1000;
  logic         clock_i, rst_n_i, nmi_n, bus_req_n, last_t, raise, irq_n, opc_n, io_n, en;
  logic [7:0]   vector, data;
  logic [1:0]   mode;
  cis_instr_t   instr;
  cis_service_t svc, got;
  int           n_fail, n_tests, n_svc, n_grant, cyc, n0;
  logic         grant;
  cis_sequencer uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .irq_n_i(irq_n), .nmi_n_i(nmi_n),
    .bus_request_n_i(bus_req_n), .last_tstate_i(last_t), .instr_i(instr), .data_i(data),
    .opcode_cycle_n_o(opc_n), .io_request_n_o(io_n), .read_n_o(), .nmi_fetch_o(),
    .bus_grant_o(grant), .service_o(svc), .irq_enabled_o(en), .irq_mode_o(mode));
  cis_periph per (.clock_i(clock_i), .rst_n_i(rst_n_i), .raise_i(raise), .vector_i(vector),
    .io_request_n_i(io_n), .opcode_cycle_n_i(opc_n), .irq_n_o(irq_n), .data_o(data));
  initial
  begin
    clock_i = 1'h0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    if (svc.valid === 1'h1)
    begin
      got = svc;
      n_svc++;
    end
    if (grant === 1'h1)
      n_grant++;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic pulse(input cis_instr_t v);
    @(negedge clock_i);
    instr = v;
    @(negedge clock_i);
    instr = '0;
  endtask
  task automatic wait_svc();
    n0 = n_svc;
    for (int k = 0; k < 40 && n_svc == n0; k++)
      @(negedge clock_i);
  endtask
  task automatic t_mask();
    pulse(IRQ_OFF);
    raise = 1'h1;
    @(negedge clock_i);
    raise = 1'h0;
    repeat (10) @(negedge clock_i);
    `CHK(n_svc, 0)
  endtask
  task automatic t_nmi();
    last_t = 1'h0;
    pulse(IRQ_ON);
    nmi_n = 1'h0;
    repeat (8) @(negedge clock_i);
    `CHK(n_svc, 0)
    last_t = 1'h1;
    wait_svc();
    nmi_n = 1'h1;
    `CHK(n_svc, 1)
    `CHK(got.nmi, 1'h1)
    `CHK(got.target, CIS_NMI_ADDR)
    `CHK(en, 1'h0)
  endtask
  task automatic t_bus();
    // The line must sit high long enough for a fresh falling edge
    pulse(IRQ_OFF);
    repeat (2) @(negedge clock_i);
    bus_req_n = 1'h0;
    nmi_n = 1'h0;
    repeat (8) @(negedge clock_i);
    `CHK(n_svc, 1)
    `CHK(n_grant > 0, 1'b1)
    bus_req_n = 1'h1;
    wait_svc();
    `CHK(n_svc, 2)
    `CHK(got.nmi, 1'h1)
    nmi_n = 1'h1;
  endtask
  task automatic t_irq(input logic [1:0] m, input logic [7:0] v, input logic [15:0] tgt);
    pulse({3'h1, m, 1'h1, 8'h5A});
    vector = v;
    raise = 1'h1;
    @(negedge clock_i);
    raise = 1'h0;
    pulse(IRQ_ON);
    wait_svc();
    `CHK(n_svc, n0 + 1)
    `CHK(got.mode, m)
    `CHK(got.target, tgt)
    `CHK(en, 1'h0)
  endtask
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    {rst_n_i, raise, vector, instr} = '0;
    {nmi_n, bus_req_n, last_t} = 3'h7;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'h1;
    repeat (3) @(negedge clock_i);
    `CHK(mode, CIS_MODE_RESET)
    t_mask();
    t_nmi();
    t_bus();
    t_irq(CIS_MODE_1, 8'h10, CIS_MODE1_ADDR);
    t_irq(CIS_MODE_2, 8'hC4, 16'h5AC4);
    t_irq(CIS_MODE_RESET, 8'hC7, 16'h0000);
    `CHK(got.opcode, 8'hC7)
    pulse({3'h1, 2'h3, 1'h0, 8'h00});
    @(negedge clock_i);
    `CHK(mode, CIS_MODE_RESET)
    conclude();
  end
endmodule
bind cis_sequencer cis_seq_sva chk (.*);
